// *** verilog/cfgmon_pkg.sv ***
// constants, types and field layout of the strap capture and fault monitor
// assumes one 50 MHz clock hclk and AHB-Lite register access
// Notes on behaviour
// - sample both shared straps leaving reset
// - shared pins stay undriven during initialization
// - firmware start turns shared pins into outputs
// - captured mode held until next reset
// - topology straps read continuously, never latched
// - decode topology pair and channel mode pair
// - modes two and three enable crossover filtering
// - outputs held off until supplies good
// - undervoltage shuts outputs, asserts all faults
// - two overcurrent thresholds per output FET
// - lower threshold flags shorts to ground/output
// - overcurrent latch holds while event persists
// - three protect inputs, action set by severity
// - peak overload steps gain down over time
// - warm temperature also steps gain down
// - warning and shutdown temperature thresholds
// - hardware thermal trip shuts down at once
// - brownout pulls reset request output low
package cfgmon_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_CONFIG = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CONTROL = 8'h08;
  localparam logic [7:0] OFS_ACTION = 8'h0C;
  localparam logic [7:0] OFS_GAIN = 8'h10;
  // reset values
  localparam logic [31:0] CONTROL_RST = 32'h0010_0000;
  localparam logic [5:0] ACTION_RST = 6'h19;
  // control fields
  localparam int CTL_FW_RUN = 0;
  localparam int CTL_DIV_LSB = 16;
  // config fields
  localparam int CFG_MODE_LSB = 0;
  localparam int CFG_TOPO_LSB = 2;
  localparam int CFG_XOVER = 4;
  localparam int CFG_MISMATCH = 5;
  localparam int CFG_STATE_LSB = 8;
  // status fields
  localparam int STS_OC_LO_LSB = 0;
  localparam int STS_OC_HI_LSB = 4;
  localparam int STS_TEMP_WARN = 8;
  localparam int STS_TEMP_SHUT = 9;
  localparam int STS_HW_THERM = 10;
  localparam int STS_UV = 11;
  localparam int STS_BO = 12;
  localparam int STS_SUP_OK = 13;
  localparam int STS_PROT_LSB = 14;
  localparam int STS_SHUTDOWN = 17;
  localparam int STS_LATCH_LSB = 20;
  // cycles the strap synchroniser needs to fill
  localparam logic [1:0] SYNC_FILL = 2'h2;
  // startup sequence
  typedef enum logic [1:0] {
    ST_RESET_SYNC = 2'b00,
    ST_CAPTURE = 2'b01,
    ST_WAIT_FW = 2'b10,
    ST_RUN = 2'b11
  } init_state_t;
  // amplifier and channel modes
  typedef enum logic [1:0] {
    MODE_0 = 2'b00,
    MODE_1 = 2'b01,
    MODE_2 = 2'b10,
    MODE_3 = 2'b11
  } cfg_mode_t;
  // response to one protect input
  typedef enum logic [1:0] {
    SEV_IGNORE = 2'b00,
    SEV_MITIGATE = 2'b01,
    SEV_SHUTDOWN = 2'b10,
    SEV_SPARE = 2'b11
  } severity_t;
  // captured configuration
  typedef struct packed {
    cfg_mode_t mode;
    logic [1:0] topo;
  } cfg_t;
  // protection inputs from pins
  typedef struct packed {
    logic [3:0] oc_lo;
    logic [3:0] oc_hi;
    logic temp_warn;
    logic temp_shut;
    logic hw_thermal;
    logic uv;
    logic bo;
    logic supply_ok;
    logic peak_ovl;
    logic [2:0] protect;
  } fault_pins_t;
endpackage : cfgmon_pkg

// *** verilog/cfg_strap_fault_monitor.sv ***
// strap capture, shared pin handover, protection and stepped gain reducer
// assumes pins are asynchronous, AHB-Lite single slave, hclk at 50 MHz
`timescale 1ns/1ps
`default_nettype none
module cfg_strap_fault_monitor #(
  parameter int GAIN_W = 3,
  parameter int STEP_HOLD = 1024,
  parameter int RELEASE = 4096
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // shared strap pins
  input wire logic supply_sync_or_strap_hi_i,
  output logic supply_sync_or_strap_hi_o,
  output logic supply_sync_or_strap_hi_oe,
  input wire logic fault_n_or_strap_lo_i,
  output logic fault_n_or_strap_lo_o,
  output logic fault_n_or_strap_lo_oe,
  // static topology straps
  input wire logic stage_topology_strap_0,
  input wire logic stage_topology_strap_1,
  // protection inputs
  input wire cfgmon_pkg::fault_pins_t fault_pins,
  // outputs to power stage and audio path
  output logic [3:0] fault_out_n,
  output logic reset_request_out_n,
  output logic power_stage_en,
  output logic xover_en,
  output logic [GAIN_W-1:0] stepped_gain_reducer
);
  import cfgmon_pkg::*;

  localparam logic [GAIN_W-1:0] GAIN_MAX = {GAIN_W{1'b1}};
  localparam logic [15:0] HOLD_RLD = 16'(STEP_HOLD - 1);
  localparam logic [15:0] REL_RLD = 16'(RELEASE - 1);

  // low byte of a word address
  function automatic logic [7:0] word_ofs(input logic [31:0] a);
    word_ofs = {a[7:2], 2'b00};
  endfunction : word_ofs

  ////////////////////////////////////////////////////////////////////////
  // synchronisers
  ////////////////////////////////////////////////////////////////////////
  logic [1:0] strap_s1_q; // first stage, read only by second
  logic [1:0] strap_s2_q;
  logic [1:0] topo_s1_q;
  logic [1:0] topo_s2_q;
  fault_pins_t f_s1_q;
  fault_pins_t f;

  // two flops on every pin input
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      strap_s1_q <= 2'h0;
      strap_s2_q <= 2'h0;
      topo_s1_q <= 2'h0;
      topo_s2_q <= 2'h0;
      f_s1_q <= '0;
      f <= '0;
    end else begin
      strap_s1_q <= {supply_sync_or_strap_hi_i, fault_n_or_strap_lo_i};
      strap_s2_q <= strap_s1_q;
      topo_s1_q <= {stage_topology_strap_1, stage_topology_strap_0};
      topo_s2_q <= topo_s1_q;
      f_s1_q <= fault_pins;
      f <= f_s1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // state
  ////////////////////////////////////////////////////////////////////////
  init_state_t state_q, state_d; // startup sequence
  logic [1:0] fill_q, fill_d; // synchroniser fill count
  cfg_mode_t mode_q, mode_d; // captured channel mode
  logic xover_q, xover_d;
  logic [3:0] oc_lat_q, oc_lat_d; // latched overcurrent per channel
  logic [3:0] fault_n_q, fault_n_d;
  logic rst_req_n_q, rst_req_n_d;
  logic power_en_q, power_en_d;
  logic [GAIN_W-1:0] gain_q, gain_d;
  logic [15:0] agc_cnt_q, agc_cnt_d; // gain step spacing
  logic [15:0] div_cnt_q, div_cnt_d; // supply sync divider
  logic sync_q, sync_d;
  logic [31:0] control_q, control_d;
  logic [5:0] action_q, action_d; // two severity bits per input
  logic dp_wr_q, dp_wr_d; // write data phase pending
  logic [7:0] dp_ofs_q, dp_ofs_d;
  logic [31:0] rdata_q, rdata_d;
  logic prot_shut;
  logic prot_mit;
  logic shutdown;
  logic all_err;
  logic agc_req;
  logic [31:0] status_w;
  logic [31:0] config_w;

  // next values for all state except the bus data phase and read data registers
  always_comb begin
    state_d = state_q;
    fill_d = fill_q;
    mode_d = mode_q;
    oc_lat_d = oc_lat_q;
    gain_d = gain_q;
    agc_cnt_d = agc_cnt_q;
    div_cnt_d = div_cnt_q;
    sync_d = sync_q;
    control_d = control_q;
    action_d = action_q;
    prot_shut = 1'b0;
    prot_mit = 1'b0;
    // protect inputs weighed by severity
    for (int i = 0; i < 3; i++) begin
      if (f.protect[i]) begin
        case (severity_t'(action_q[2*i +: 2]))
          SEV_MITIGATE: prot_mit = 1'b1;
          SEV_SHUTDOWN: prot_shut = 1'b1;
          default: ;
        endcase
      end
    end
    // conditions that stop the power stage and flag every channel; hardware thermal trip only stops the power stage
    all_err = f.uv | ~f.supply_ok | f.temp_shut | prot_shut;
    shutdown = all_err | f.hw_thermal;
    // startup sequencing
    case (state_q)
      ST_RESET_SYNC: begin
        fill_d = fill_q + 2'h1;
        if (fill_q == SYNC_FILL - 2'h1) begin
          state_d = ST_CAPTURE;
        end
      end
      ST_CAPTURE: begin
        mode_d = cfg_mode_t'(strap_s2_q);
        state_d = ST_WAIT_FW;
      end
      ST_WAIT_FW: begin
        if (control_q[CTL_FW_RUN]) begin
          state_d = ST_RUN;
        end
      end
      ST_RUN: ; // mode never resampled here
      default: state_d = ST_RESET_SYNC;
    endcase
    xover_d = (mode_d == MODE_2) || (mode_d == MODE_3);
    // overcurrent latch: event sets, software clears once it is gone
    if (dp_wr_q && dp_ofs_q == OFS_STATUS) begin
      oc_lat_d = oc_lat_q & ~hwdata[STS_LATCH_LSB +: 4];
    end
    oc_lat_d = oc_lat_d | f.oc_lo | f.oc_hi;
    fault_n_d = ~(oc_lat_d | {4{all_err}});
    rst_req_n_d = ~f.bo;
    power_en_d = (state_q == ST_RUN) && f.supply_ok && !shutdown;
    // stepped gain reduction
    agc_req = f.peak_ovl | f.temp_warn | prot_mit;
    if (agc_cnt_q != 16'h0) begin
      agc_cnt_d = agc_cnt_q - 16'h1;
    end else if (agc_req && gain_q != GAIN_MAX) begin
      gain_d = gain_q + 1'b1;
      agc_cnt_d = HOLD_RLD;
    end else if (!agc_req && gain_q != '0) begin
      gain_d = gain_q - 1'b1;
      agc_cnt_d = REL_RLD;
    end
    // supply sync square wave, half period from control
    if (div_cnt_q >= control_q[CTL_DIV_LSB +: 16]) begin
      div_cnt_d = 16'h0;
      sync_d = ~sync_q;
    end else begin
      div_cnt_d = div_cnt_q + 16'h1;
    end
    // register writes in the data phase
    if (dp_wr_q) begin
      case (dp_ofs_q)
        OFS_CONTROL: control_d = hwdata;
        OFS_ACTION: action_d = hwdata[5:0];
        default: ;
      endcase
    end
  end

  // readable views
  assign config_w = {22'h0, state_q, 2'h0, (topo_s2_q != mode_q),
                     xover_q, topo_s2_q, mode_q};
  assign status_w = {8'h0, oc_lat_q, 2'h0, shutdown, f.protect,
                     f.supply_ok, f.bo, f.uv, f.hw_thermal, f.temp_shut,
                     f.temp_warn, f.oc_hi, f.oc_lo};

  // bus address phase and read data
  always_comb begin
    dp_wr_d = 1'b0;
    dp_ofs_d = dp_ofs_q;
    rdata_d = rdata_q;
    if (hsel && htrans[1] && hready) begin
      dp_wr_d = hwrite;
      dp_ofs_d = word_ofs(haddr);
      if (!hwrite) begin
        case (word_ofs(haddr))
          OFS_CONFIG: rdata_d = config_w;
          OFS_STATUS: rdata_d = status_w;
          OFS_CONTROL: rdata_d = control_q;
          OFS_ACTION: rdata_d = {26'h0, action_q};
          OFS_GAIN: rdata_d = {{(32-GAIN_W){1'b0}}, gain_q};
          default: rdata_d = 32'h0; // unmapped reads zero
        endcase
      end
    end
  end

  // register all state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_RESET_SYNC;
      fill_q <= 2'h0;
      mode_q <= MODE_0;
      xover_q <= 1'b0;
      oc_lat_q <= 4'h0;
      fault_n_q <= 4'hF;
      rst_req_n_q <= 1'b1;
      power_en_q <= 1'b0;
      gain_q <= '0;
      agc_cnt_q <= 16'h0;
      div_cnt_q <= 16'h0;
      sync_q <= 1'b0;
      control_q <= CONTROL_RST;
      action_q <= ACTION_RST;
      dp_wr_q <= 1'b0;
      dp_ofs_q <= 8'h0;
      rdata_q <= 32'h0;
    end else begin
      state_q <= state_d;
      fill_q <= fill_d;
      mode_q <= mode_d;
      xover_q <= xover_d;
      oc_lat_q <= oc_lat_d;
      fault_n_q <= fault_n_d;
      rst_req_n_q <= rst_req_n_d;
      power_en_q <= power_en_d;
      gain_q <= gain_d;
      agc_cnt_q <= agc_cnt_d;
      div_cnt_q <= div_cnt_d;
      sync_q <= sync_d;
      control_q <= control_d;
      action_q <= action_d;
      dp_wr_q <= dp_wr_d;
      dp_ofs_q <= dp_ofs_d;
      rdata_q <= rdata_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs
  ////////////////////////////////////////////////////////////////////////
  assign hreadyout = 1'b1; // zero wait states
  assign hresp = 1'b0; // always okay
  assign hrdata = rdata_q;
  // shared pins driven only once firmware runs
  assign supply_sync_or_strap_hi_oe = (state_q == ST_RUN);
  assign fault_n_or_strap_lo_oe = (state_q == ST_RUN);
  assign supply_sync_or_strap_hi_o = sync_q;
  assign fault_n_or_strap_lo_o = &fault_n_q;
  assign fault_out_n = fault_n_q;
  assign reset_request_out_n = rst_req_n_q;
  assign power_stage_en = power_en_q;
  assign xover_en = xover_q;
  assign stepped_gain_reducer = gain_q;

  ////////////////////////////////////////////////////////////////////////
  // assertions
  ////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  // capture step follows a filled synchroniser
  sequence s_fill;
    (state_q == ST_RESET_SYNC) [*2];
  endsequence
  sequence s_capture;
    (state_q == ST_CAPTURE);
  endsequence

  a_capture_after_fill: assert property (
    s_fill ##1 s_capture |=> (mode_q == $past(strap_s2_q))
      && (state_q == ST_WAIT_FW))
    else $error("strap capture mistimed");
  a_mode_held: assert property (
    (state_q == ST_WAIT_FW || state_q == ST_RUN) |=> $stable(mode_q))
    else $error("captured mode changed");
  a_pins_undriven: assert property (
    (state_q != ST_RUN) |-> !supply_sync_or_strap_hi_oe
      && !fault_n_or_strap_lo_oe)
    else $error("shared pin driven during init");
  a_pins_handover: assert property (
    (state_q == ST_WAIT_FW && control_q[CTL_FW_RUN]) |=>
      fault_n_or_strap_lo_oe && supply_sync_or_strap_hi_oe)
    else $error("shared pins not handed over");
  a_xover_mode: assert property (
    (state_q == ST_RUN) |-> xover_en == mode_q[1])
    else $error("crossover enable wrong for mode");
  a_supply_holdoff: assert property (
    !f.supply_ok |=> !power_stage_en)
    else $error("power stage on with bad supply");
  a_uv_faults: assert property (
    f.uv |=> (fault_out_n == 4'h0) && !power_stage_en)
    else $error("undervoltage not reported");
  a_oc_latched: assert property (
    (f.oc_lo[0] || f.oc_hi[0]) |=> oc_lat_q[0] && !fault_out_n[0])
    else $error("overcurrent not latched");
  a_thermal_trip: assert property (
    f.hw_thermal |=> !power_stage_en)
    else $error("thermal trip ignored");
  a_brownout_req: assert property (
    f.bo |=> !reset_request_out_n ##1 (reset_request_out_n == !$past(f.bo)))
    else $error("brownout reset request wrong");
  a_gain_step: assert property (
    ($changed(gain_q)) |=> $stable(gain_q) [*2])
    else $error("gain stepped too fast");
endmodule : cfg_strap_fault_monitor
`default_nettype wire

// *** testbench/strap_board_model.sv ***
// board strap resistors on the shared and topology pins
// assumes the monitor splits each shared pin into in, out and enable
`timescale 1ns/1ps
`default_nettype none
module strap_board_model (
  // strap settings chosen by the bench
  input wire logic [1:0] mode_strap,
  input wire logic [1:0] topo_strap,
  // shared pins, monitor side
  input wire logic hi_o,
  input wire logic hi_oe,
  input wire logic lo_o,
  input wire logic lo_oe,
  // resolved pin levels back to the monitor
  output logic hi_i,
  output logic lo_i,
  output logic topo_0,
  output logic topo_1
);
  // pull resistor sets the level only while the pin is released
  assign hi_i = hi_oe ? hi_o : mode_strap[1];
  assign lo_i = lo_oe ? lo_o : mode_strap[0];
  // topology resistors stay static during operation
  assign topo_0 = topo_strap[0];
  assign topo_1 = topo_strap[1];
endmodule : strap_board_model
`default_nettype wire

// *** testbench/tb_cfg_strap_fault_monitor.sv ***
// bench for strap capture, pin handover and fault monitor
// assumes strap_board_model resolves shared pins, bench drives fault pins
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin compares++; if ((g) !== (e)) begin \
  err_total++; $display("mismatch %s exp %h got %h", n, e, g); end end
module tb_cfg_strap_fault_monitor;
  import cfgmon_pkg::*;
  ////////////////////////////////////////////////////////////////////////
  // short counts so gain steps fit the run
  localparam int HOLD = 4;
  localparam int REL = 8;
  localparam logic [17:0] OK = 18'h00010;
  // one row: fault pins and the outputs they should give
  typedef struct packed {
    fault_pins_t pins;
    logic [3:0] flt;
    logic en;
    logic rr;
  } row_t;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b1;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic hi_i, hi_o, hi_oe, lo_i, lo_o, lo_oe, topo_0, topo_1;
  logic [1:0] mode_strap = 2'h2;
  logic [1:0] topo_strap = 2'h2;
  fault_pins_t fault_pins = OK;
  logic [3:0] fault_out_n;
  logic rr_n, pen, xen;
  logic [2:0] gain;
  logic [31:0] q;
  logic s0; // last seen supply sync level
  int k; // bounded wait count
  int err_total = 0;
  int compares = 0;
  row_t rows [7];
  ////////////////////////////////////////////////////////////////////////
  // free running 50 MHz clock
  initial begin
    forever #10 hclk = ~hclk;
  end
  cfg_strap_fault_monitor #(.GAIN_W(3), .STEP_HOLD(HOLD), .RELEASE(REL))
    i_cfg_strap_fault_monitor (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
    .supply_sync_or_strap_hi_i(hi_i), .supply_sync_or_strap_hi_o(hi_o),
    .supply_sync_or_strap_hi_oe(hi_oe), .fault_n_or_strap_lo_i(lo_i),
    .fault_n_or_strap_lo_o(lo_o), .fault_n_or_strap_lo_oe(lo_oe),
    .stage_topology_strap_0(topo_0), .stage_topology_strap_1(topo_1),
    .fault_pins(fault_pins), .fault_out_n(fault_out_n),
    .reset_request_out_n(rr_n), .power_stage_en(pen), .xover_en(xen),
    .stepped_gain_reducer(gain));
  strap_board_model i_strap_board_model (.mode_strap(mode_strap),
    .topo_strap(topo_strap), .hi_o(hi_o), .hi_oe(hi_oe), .lo_o(lo_o),
    .lo_oe(lo_oe), .hi_i(hi_i), .lo_i(lo_i), .topo_0(topo_0),
    .topo_1(topo_1));
  ////////////////////////////////////////////////////////////////////////
  // verdict and end of run
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : wrap_up
  // one single word transfer, entered just after a rising edge
  task automatic bus(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    hwrite <= wr;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do begin @(posedge hclk); n++; end while (hreadyout !== 1'b1 && n < 99);
    q = hrdata;
    if (n >= 99) begin
      err_total++;
      wrap_up();
    end
  endtask : bus
  // let a pin change reach the outputs
  task automatic settle();
    repeat (5) @(posedge hclk);
  endtask : settle
  ////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rows[0] = {OK, 4'hF, 1'b1, 1'b1};
    rows[1] = {18'h00000, 4'h0, 1'b0, 1'b1};
    rows[2] = {18'h00050, 4'h0, 1'b0, 1'b1};
    rows[3] = {18'h00110, 4'h0, 1'b0, 1'b1};
    rows[4] = {18'h00090, 4'hF, 1'b0, 1'b1};
    rows[5] = {18'h00030, 4'hF, 1'b1, 1'b0};
    rows[6] = {18'h00012, 4'h0, 1'b0, 1'b1};
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    settle();
    // capture and reset values before firmware start
    `CHK("oe", 2'h0, {hi_oe, lo_oe})
    bus(1'b0, OFS_CONTROL, 32'h0);
    `CHK("control", CONTROL_RST, q)
    bus(1'b0, OFS_ACTION, 32'h0);
    `CHK("action", {26'h0, ACTION_RST}, q)
    bus(1'b0, 8'h20, 32'h0);
    `CHK("unmapped", 32'h0, q)
    `CHK("resp", 2'h2, {hreadyout, hresp})
    bus(1'b0, OFS_CONFIG, 32'h0);
    `CHK("config", 32'h0000_021A, q)
    `CHK("xover", 1'b1, xen)
    mode_strap <= 2'h1;
    topo_strap <= 2'h1;
    settle();
    bus(1'b0, OFS_CONFIG, 32'h0);
    `CHK("held", 32'h0000_0236, q)
    mode_strap <= 2'h2;
    topo_strap <= 2'h2;
    bus(1'b1, OFS_CONTROL, CONTROL_RST | 32'h1);
    settle();
    `CHK("oe run", 2'h3, {hi_oe, lo_oe})
    `CHK("fault pin", 1'b1, lo_o)
    bus(1'b0, OFS_CONFIG, 32'h0);
    `CHK("run", 32'h0000_031A, q)
    // supply sync output flips every divider half period
    s0 = hi_o;
    k = 0;
    while (hi_o === s0 && k < 40) begin
      @(posedge hclk);
      k++;
    end
    if (k >= 40) begin
      err_total++;
      wrap_up();
    end
    s0 = hi_o;
    repeat (CONTROL_RST[CTL_DIV_LSB +: 16]) @(posedge hclk);
    `CHK("sync hold", s0, hi_o)
    @(posedge hclk);
    `CHK("sync flip", ~s0, hi_o)
    $display("test straps done");
    // ordinary fault cases
    foreach (rows[i]) begin
      fault_pins <= rows[i].pins;
      settle();
      `CHK("faults", rows[i].flt, fault_out_n)
      `CHK("power", rows[i].en, pen)
      `CHK("reset req", rows[i].rr, rr_n)
      fault_pins <= OK;
      settle();
    end
    $display("test rows done");
    // overcurrent latch holds past the event until cleared
    fault_pins <= 18'h08010;
    settle();
    `CHK("oc lo", 4'hD, fault_out_n)
    `CHK("oc pin", 1'b0, lo_o)
    bus(1'b1, OFS_STATUS, 32'h0020_0000);
    settle();
    `CHK("oc kept", 4'hD, fault_out_n)
    fault_pins <= OK;
    settle();
    `CHK("oc latch", 4'hD, fault_out_n)
    bus(1'b0, OFS_STATUS, 32'h0);
    `CHK("status", 32'h0020_2000, q)
    bus(1'b1, OFS_STATUS, 32'h0020_0000);
    settle();
    `CHK("oc clear", 4'hF, fault_out_n)
    fault_pins <= 18'h01010;
    settle();
    `CHK("oc hi", 4'hB, fault_out_n)
    fault_pins <= OK;
    settle();
    bus(1'b1, OFS_STATUS, 32'h0040_0000);
    settle();
    `CHK("oc hi clr", 4'hF, fault_out_n)
    $display("test overcurrent done");
    // each gain cause climbs to the top step, then releases to none
    foreach (rows[i]) begin
      if (i < 3) begin
        fault_pins <= (i == 0) ? 18'h00018 : (i == 1) ? 18'h00210 : 18'h00011;
        repeat (HOLD * 7 + 30) @(posedge hclk);
        `CHK("gain max", 3'h7, gain)
        fault_pins <= OK;
        repeat (REL * 7 + 40) @(posedge hclk);
        `CHK("gain none", 3'h0, gain)
      end
    end
    $display("test gain done");
    // rewritten action table turns protect input 0 into a shutdown
    bus(1'b1, OFS_ACTION, 32'h0000_0002);
    bus(1'b0, OFS_ACTION, 32'h0);
    `CHK("action wr", 32'h0000_0002, q)
    fault_pins <= 18'h00011;
    settle();
    `CHK("prot shut", 5'h00, {fault_out_n, pen})
    fault_pins <= OK;
    settle();
    `CHK("prot gone", 5'h1F, {fault_out_n, pen})
    $display("test action done");
    // second reset recaptures a new mode
    hresetn <= 1'b0;
    mode_strap <= 2'h1;
    topo_strap <= 2'h1;
    settle();
    `CHK("rst out", 7'h7A, {fault_out_n, pen, rr_n, gain[0]})
    `CHK("rst oe", 2'h0, {hi_oe, lo_oe})
    hresetn <= 1'b1;
    settle();
    bus(1'b0, OFS_CONFIG, 32'h0);
    `CHK("recapture", 32'h0000_0205, q)
    `CHK("xover off", 1'b0, xen)
    bus(1'b0, OFS_ACTION, 32'h0);
    `CHK("action rst", {26'h0, ACTION_RST}, q)
    $display("test reset done");
    wrap_up();
  end
endmodule : tb_cfg_strap_fault_monitor
`default_nettype wire
